// [bench/ifd_decoder_bench.sv]
// self-checking bench for the instruction format decoder
`timescale 1ns/1ns
`default_nettype none
`include "ifd_consts.vh"
`define CHK(nm, e, g) begin \
    tests_run++; \
    if ((e) !== (g)) begin \
        errors++; \
        $display("wrong value %s expected %h seen %h", nm, e, g); \
    end \
end
module ifd_decoder_bench;
    logic        clock = 0, sys_rst = 1, instr_valid = 0, irq_req = 0;
    logic        flag_n = 0, flag_z = 0, flag_v = 0, flag_c = 0;
    logic [15:0] instr = 0, next_pc = 0, count_value = 0, w;
    logic [7:0]  k;
    logic [37:0] n, notes[$];
    int          errors = 0, tests_run = 0, i;
    wire         decode_valid, byte_op, is_subtract, branch_taken, trap_req, status_write;
    wire         status_read, proc_type_read, reserved_instr, call_pc_link;
    wire [2:0]   src_mode, src_reg, dst_mode, dst_reg, trap_kind;
    wire [3:0]   class_code;
    wire [8:0]   opcode;
    wire [15:0]  branch_target, count_result, proc_type;
    logic [15:0] tw[11] = '{16'o104123, 16'o104456, `IFD_BREAK_TRAP, `IFD_IO_TRAP, 16'o106427,
                            16'o106701, `IFD_HALT, `IFD_WAIT, `IFD_READ_PTYPE, 16'o10,
                            16'o170000};
    logic [3:0]  tc[11] = '{4'h9, 4'h9, 4'h9, 4'h9, 4'hB, 4'hB, 4'hA, 4'hA, 4'hA, 4'h0, 4'h0};
    ifd_decoder dut (.*);
    always #50 clock = ~clock;
    // branch condition from the four flags
    function automatic logic br(input [7:0] c);
        logic [7:0] t;
        t = {flag_c, flag_v, flag_c | flag_z, flag_n, flag_z | flag_n ^ flag_v, flag_n ^ flag_v,
             flag_z, 1'b1};
        return c == 8'h01 || t[{c[7], c[2:1]}] == c[0];
    endfunction
    task automatic send(input [15:0] wd, input [3:0] m, input [3:0] c, input [1:0] bs,
                        input [11:0] fl, input [15:0] t);
        instr = wd;
        instr_valid = 1;
        notes.push_back({m, c, bs, fl, t});
        @(negedge clock);
    endtask
    task automatic tally_and_finish;
        if (errors == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // compare each decoded word against the oldest note
    always @(posedge clock) begin
        #1;
        if (decode_valid === 1'b1) begin
            n = notes.size() ? notes.pop_front() : 38'h0;
            `CHK("class", n[33:30], class_code)
            `CHK("taken", n[34], branch_taken)
            if (n[36]) `CHK("dst", {n[29:28], n[21:16]}, {byte_op, is_subtract, dst_mode, dst_reg})
            if (n[37]) `CHK("src", n[27:22], {src_mode, src_reg})
            if (n[35]) `CHK("target", n[15:0], branch_target)
        end
    end
    initial begin
        void'($urandom(32'h1906));
        repeat (10) @(negedge clock);
        sys_rst = 0;
        for (i = 0; i < 8; i++) begin
            w = $urandom;
            w[14:6] = 9'o050 + i;
            send(w, 4'h4, 4'h1, {w[15], 1'b0}, w[5:0], 0);
        end
        for (i = 0; i < 12; i++) begin
            w = $urandom;
            w[15:12] = {i > 5, 3'(i % 6 + 1)};
            k = {w[15] & w[14:12] != 6, w[15] & w[14:12] == 6};
            send(w, 4'hC, 4'h2, k[1:0], w[11:0], 0);
        end
        for (i = 0; i < 5; i++) begin
            w = $urandom;
            w[15:9] = 7'o070 + i;
            if (i < 4) send(w, 4'h8, 4'h3, 0, {w[5:0], 6'h0}, 0);
            else send(w, 4'hC, 4'h4, 0, {3'h0, w[8:0]}, 0);
        end
        for (i = 0; i < 30; i++) begin
            k = i % 15 < 7 ? i % 15 + 1 : 8'h79 + i % 15;
            {flag_n, flag_z, flag_v, flag_c} = $urandom;
            next_pc = $urandom;
            w = $urandom;
            w[15:8] = k;
            if (i < 2) w[7:0] = 8'h7f + i;
            send(w, {3'b001, br(k)}, 4'h5, 0, 0, next_pc + {{7{w[7]}}, w[7:0], 1'b0});
        end
        for (i = 0; i < 4; i++) begin
            count_value = i < 2 ? i + 1 : $urandom;
            next_pc = $urandom;
            w = {`IFD_CNTBR_OP7, 9'($urandom)};
            send(w, {3'b001, count_value != 1}, 4'h6, 0, 0, next_pc - {w[5:0], 1'b0});
        end
        send(16'o004767, 4'h4, 4'h7, 0, 12'o0067, 0);
        send(16'o004537, 4'h4, 4'h7, 0, 12'o0037, 0);
        send(16'o000205, 4'h0, 4'h8, 0, 0, 0);
        for (i = 0; i < 11; i++) send(tw[i], 4'h0, tc[i], 0, 0, 0);
        instr_valid = 0;
        irq_req = 1;
        for (i = 0; i < 6 && trap_req !== 1'b1; i++) @(negedge clock);
        `CHK("irq", {trap_req, trap_kind}, {1'b1, `IFD_TRP_IRQ})
        irq_req = 0;
        repeat (4) @(negedge clock);
        `CHK("pending", notes.size(), 0)
        tally_and_finish;
    end
endmodule
`default_nettype wire

// [bench/ifd_decoder_properties.sv]
// port assertions for the instruction format decoder
`timescale 1ns/1ns
`default_nettype none
`include "ifd_consts.vh"
module ifd_decoder_properties (
    input wire logic        clock,
    input wire logic        sys_rst,
    input wire logic        instr_valid,
    input wire logic [15:0] instr,
    input wire logic [15:0] next_pc,
    input wire logic        irq_req,
    input wire logic [15:0] count_value,
    input wire logic [3:0]  class_code,
    input wire logic [8:0]  opcode,
    input wire logic        status_write,
    input wire logic        status_read,
    input wire logic        proc_type_read,
    input wire logic [15:0] proc_type,
    input wire logic        byte_op,
    input wire logic        is_subtract,
    input wire logic [2:0]  src_mode,
    input wire logic [2:0]  src_reg,
    input wire logic [2:0]  dst_mode,
    input wire logic [2:0]  dst_reg,
    input wire logic        branch_taken,
    input wire logic [15:0] branch_target,
    input wire logic [15:0] count_result,
    input wire logic        trap_req,
    input wire logic [2:0]  trap_kind,
    input wire logic        reserved_instr,
    input wire logic        call_pc_link
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (sys_rst);
    property p_double;
        instr_valid && instr[14:12] == 3'o6 |=> class_code == `IFD_CLS_DOUBLE && !byte_op
            && is_subtract == $past(instr[15])
            && {src_mode, src_reg, dst_mode, dst_reg} == $past(instr[11:0]);
    endproperty
    a_double: assert property (p_double) else $error("add or subtract wrong");
    property p_regdst;
        instr_valid && instr[15:9] == 7'o071 |=> class_code == `IFD_CLS_REGDST
            && dst_reg == $past(instr[8:6]) && {src_mode, src_reg} == $past(instr[5:0]);
    endproperty
    a_regdst: assert property (p_regdst) else $error("register form wrong");
    property p_branch;
        instr_valid && instr[15:8] == 8'h01 |=> branch_taken
            && branch_target == $past(next_pc) + {{7{$past(instr[7])}}, $past(instr[7:0]), 1'b0};
    endproperty
    a_branch: assert property (p_branch) else $error("branch target wrong");
    property p_decbr;
        instr_valid && instr[15:9] == `IFD_CNTBR_OP7 |=> count_result == $past(count_value) - 1'b1
            && branch_taken == ($past(count_value) != 16'h0001);
    endproperty
    a_decbr: assert property (p_decbr) else $error("decrement branch wrong");
    property p_call;
        instr_valid && instr[15:9] == `IFD_CALL_OP7 |=> class_code == `IFD_CLS_CALL
            && src_reg == $past(instr[8:6]) && call_pc_link == ($past(instr[8:6]) == 3'o7);
    endproperty
    a_call: assert property (p_call) else $error("call decode wrong");
    property p_return;
        instr_valid && instr[15:3] == `IFD_RET_OP13 |=> class_code == `IFD_CLS_RETURN
            && dst_reg == $past(instr[2:0]);
    endproperty
    a_return: assert property (p_return) else $error("return decode wrong");
    property p_trap;
        (!irq_req) [*4] ##0 (instr_valid && instr == `IFD_BREAK_TRAP) |=> trap_req && trap_kind == 3'h3;
    endproperty
    a_trap: assert property (p_trap) else $error("trap request wrong");
    property p_resv;
        instr_valid && instr[15:12] == 4'hF |=> reserved_instr && class_code == 4'h0;
    endproperty
    a_resv: assert property (p_resv) else $error("reserved flag wrong");
    property p_single;
        instr_valid && instr[14:9] == 6'o05 |=> class_code == `IFD_CLS_SINGLE
            && opcode == $past(instr[14:6]) && byte_op == $past(instr[15]);
    endproperty
    a_single: assert property (p_single) else $error("single operand wrong");
    property p_status;
        instr_valid && (instr[15:6] == `IFD_WR_STATUS_OP10 || instr[15:6] == `IFD_RD_STATUS_OP10)
            |=> class_code == `IFD_CLS_STATUS && status_write == !$past(instr[6])
            && status_read == $past(instr[6]);
    endproperty
    a_status: assert property (p_status) else $error("status byte move wrong");
    property p_ptype;
        instr_valid && instr == `IFD_READ_PTYPE |=> proc_type_read && proc_type == `IFD_PROC_TYPE;
    endproperty
    a_ptype: assert property (p_ptype) else $error("processor type wrong");
endmodule
bind ifd_decoder ifd_decoder_properties chk (.*);
`default_nettype wire

// [rtl/ifd_consts.vh]
// constants for the instruction format decoder
`ifndef IFD_CONSTS_VH
`define IFD_CONSTS_VH
// operation classes (class_code output)
`define IFD_CLS_RESERVED   4'h0
`define IFD_CLS_SINGLE     4'h1
`define IFD_CLS_DOUBLE     4'h2
`define IFD_CLS_REGDST     4'h3
`define IFD_CLS_XOR        4'h4
`define IFD_CLS_BRANCH     4'h5
`define IFD_CLS_CNT_BR     4'h6
`define IFD_CLS_CALL       4'h7
`define IFD_CLS_RETURN     4'h8
`define IFD_CLS_TRAP       4'h9
`define IFD_CLS_MISC       4'hA
`define IFD_CLS_STATUS     4'hB
`define IFD_CLS_CCODE      4'hC
// fixed opcodes (octal values of the upper fields) and the pc/sp register numbers
`define IFD_CALL_OP7       7'o004
`define IFD_RET_OP13       13'o00020
`define IFD_XOR_OP7        7'o074
`define IFD_CNTBR_OP7      7'o077
`define IFD_ADDSUB_OP3     3'o6
`define IFD_REGDST_TOP4    4'o07
`define IFD_PC_REG         3'o7
`define IFD_SP_REG         3'o6
// single-word special codes
`define IFD_HALT           16'o000000
`define IFD_WAIT           16'o000001
`define IFD_RTI            16'o000002
`define IFD_BREAK_TRAP     16'o000003
`define IFD_IO_TRAP        16'o000004
`define IFD_RESET          16'o000005
`define IFD_RTT            16'o000006
`define IFD_READ_PTYPE     16'o000007
`define IFD_WR_STATUS_OP10 10'o1064
`define IFD_RD_STATUS_OP10 10'o1067
`define IFD_EMUL_OP8       8'o210
`define IFD_TRAP_OP8       8'o211
// trap kinds
`define IFD_TRP_NONE       3'h0
`define IFD_TRP_EMUL       3'h1
`define IFD_TRP_TRAP       3'h2
`define IFD_TRP_BREAK      3'h3
`define IFD_TRP_IO         3'h4
`define IFD_TRP_IRQ        3'h5
// arbitrary processor type code
`define IFD_PROC_TYPE      16'h0003
`endif

// [rtl/ifd_decoder.v]
// instruction format decoder with branch test and target
// Notes on behaviour
// RULE_01: single operand: byte bit, opcode, destination
// RULE_02: double operand: opcode, source, destination fields
// RULE_03: opcode 6 bit 15 picks add/subtract
// RULE_04: source and destination fields decoded independently
// RULE_05: shift/multiply/divide: op, dst register, source
// RULE_06: xor: register source, full destination field
// RULE_07: bit 15 selects byte variant
// RULE_08: no byte add; bit 15 means subtract
// RULE_09: branch: condition code byte, word offset
// RULE_10: all listed branch conditions are supported
// RULE_11: decrement register, branch when not zero
// RULE_12: call when bits 15-9 are 004
// RULE_13: call link register never stack pointer; a link field of 6 still decodes as a call
// RULE_14: only pc may be link and destination
// RULE_15: return when bits 15-3 are 00020
// RULE_16: return register matches call link register; not checked, dst_reg is taken from bits 2-0 with no call history
// RULE_17: traps and interrupts force handler jump
// RULE_18: move byte to and from status
// RULE_19: instruction returns processor type code
// RULE_20: branch tests use n z v c
// RULE_21: target is pc plus twice offset
// RULE_22: undefined words flagged as reserved
`timescale 1ns/1ns
`default_nettype none
`include "ifd_consts.vh"
module ifd_decoder #(
    parameter WIDTH = 16
) (
    input  wire             clock,
    input  wire             sys_rst,
    input  wire             instr_valid,
    input  wire [WIDTH-1:0] instr,
    input  wire [WIDTH-1:0] next_pc,
    input  wire             flag_n,
    input  wire             flag_z,
    input  wire             flag_v,
    input  wire             flag_c,
    input  wire             irq_req,
    input  wire [WIDTH-1:0] count_value,
    output reg              decode_valid,
    output reg  [3:0]       class_code,
    output reg  [8:0]       opcode,
    output reg              byte_op,
    output reg              is_subtract,
    output reg  [2:0]       src_mode,
    output reg  [2:0]       src_reg,
    output reg  [2:0]       dst_mode,
    output reg  [2:0]       dst_reg,
    output reg              branch_taken,
    output reg  [WIDTH-1:0] branch_target,
    output reg  [WIDTH-1:0] count_result,
    output reg              trap_req,
    output reg  [2:0]       trap_kind,
    output reg              status_write,
    output reg              status_read,
    output reg              proc_type_read,
    output reg  [WIDTH-1:0] proc_type,
    output reg              reserved_instr,
    output reg              call_pc_link
);

    // condition test for branch code byte
    function cond_ok;
        input [7:0] code;
        input       n, z, v, c;
        begin
            case ({code[7], code[2:0]})
                4'h1:    cond_ok = 1'b1;                 // always
                4'h2:    cond_ok = ~z;
                4'h3:    cond_ok = z;
                4'h4:    cond_ok = ~(n ^ v);             // signed ge
                4'h5:    cond_ok = n ^ v;                // signed lt
                4'h6:    cond_ok = ~(z | (n ^ v));       // signed gt
                4'h7:    cond_ok = z | (n ^ v);          // signed le
                4'h8:    cond_ok = ~n;
                4'h9:    cond_ok = n;
                4'hA:    cond_ok = ~(c | z);             // higher
                4'hB:    cond_ok = c | z;                // lower or same
                4'hC:    cond_ok = ~v;
                4'hD:    cond_ok = v;
                4'hE:    cond_ok = ~c;                   // higher or same
                4'hF:    cond_ok = c;                    // lower
                default: cond_ok = 1'b0;
            endcase
        end
    endfunction

    reg [3:0]       next_class;
    reg [8:0]       next_opcode;
    reg             next_byte;
    reg             next_sub;
    reg [2:0]       next_smode;
    reg [2:0]       next_sreg;
    reg [2:0]       next_dmode;
    reg [2:0]       next_dreg;
    reg             next_taken;
    reg [WIDTH-1:0] next_target;
    reg [WIDTH-1:0] next_decval;
    reg [2:0]       next_trap;
    reg             next_swr;
    reg             next_srd;
    reg             next_ptr;
    reg             irq_meta;
    reg             irq_sync;
    wire [WIDTH-1:0] off_ext = {{(WIDTH-9){instr[7]}}, instr[7:0], 1'b0};
    wire [WIDTH-1:0] sob_ext = {{(WIDTH-7){1'b0}}, instr[5:0], 1'b0};
    wire [WIDTH-1:0] count_less_one = count_value - {{(WIDTH-1){1'b0}}, 1'b1};

    always @* begin
        next_class  = `IFD_CLS_RESERVED;
        next_opcode = 9'h000;
        next_byte   = 1'b0;
        next_sub    = 1'b0;
        next_smode  = instr[11:9];                        // RULE_04
        next_sreg   = instr[8:6];
        next_dmode  = instr[5:3];                         // RULE_04
        next_dreg   = instr[2:0];
        next_taken  = 1'b0;
        next_target = next_pc;
        next_decval = count_value;
        next_trap   = `IFD_TRP_NONE;
        next_swr    = 1'b0;
        next_srd    = 1'b0;
        next_ptr    = 1'b0;
        if (instr[14:12] != 3'o0 && instr[14:12] != 3'o7) begin
            next_class  = `IFD_CLS_DOUBLE;                // RULE_02
            next_opcode = {6'h00, instr[14:12]};
            if (instr[14:12] == `IFD_ADDSUB_OP3) begin
                next_sub = instr[15];                     // RULE_03 RULE_08
            end else begin
                next_byte = instr[15];                    // RULE_07
            end
        end else if (instr[15:12] == `IFD_REGDST_TOP4) begin
            next_opcode = {2'h0, instr[15:9]};
            next_dreg   = instr[8:6];                     // RULE_05
            next_dmode  = 3'o0;
            next_smode  = instr[5:3];
            next_sreg   = instr[2:0];
            if (instr[11:9] <= 3'o3) begin
                next_class = `IFD_CLS_REGDST;             // RULE_05
            end else if (instr[15:9] == `IFD_XOR_OP7) begin
                next_class = `IFD_CLS_XOR;                // RULE_06
                next_smode = 3'o0;
                next_sreg  = instr[8:6];
                next_dmode = instr[5:3];
                next_dreg  = instr[2:0];
            end else if (instr[15:9] == `IFD_CNTBR_OP7) begin
                next_class  = `IFD_CLS_CNT_BR;
                next_decval = count_less_one;             // RULE_11
                next_taken  = (count_less_one != {WIDTH{1'b0}}); // RULE_11
                next_target = next_pc - sob_ext;
            end
        end else if (instr[14:11] == 4'h0 && (instr[15] || instr[10:8] != 3'o0)) begin
            next_class  = `IFD_CLS_BRANCH;                // RULE_09
            next_opcode = {1'b0, instr[15:8]};
            next_taken  = cond_ok(instr[15:8], flag_n, flag_z, flag_v, flag_c); // RULE_10 RULE_20
            next_target = next_pc + off_ext;              // RULE_21
        end else if (instr[15:9] == `IFD_CALL_OP7) begin
            next_class  = `IFD_CLS_CALL;                  // RULE_12
            next_opcode = {2'h0, instr[15:9]};
            next_sreg   = instr[8:6];
            next_smode  = 3'o0;
        end else if (instr[15:3] == `IFD_RET_OP13) begin
            next_class  = `IFD_CLS_RETURN;                // RULE_15
            next_dreg   = instr[2:0];
            next_dmode  = 3'o0;
        end else if (instr[15:8] == `IFD_EMUL_OP8 || instr[15:8] == `IFD_TRAP_OP8) begin
            next_class = `IFD_CLS_TRAP;                   // RULE_17
            next_trap  = instr[8] ? `IFD_TRP_TRAP : `IFD_TRP_EMUL;
        end else if (instr == `IFD_BREAK_TRAP || instr == `IFD_IO_TRAP) begin
            next_class = `IFD_CLS_TRAP;                   // RULE_17
            next_trap  = instr[2] ? `IFD_TRP_IO : `IFD_TRP_BREAK;
        end else if (instr == `IFD_READ_PTYPE) begin
            next_class = `IFD_CLS_MISC;
            next_ptr   = 1'b1;                            // RULE_19
        end else if (instr[15:0] <= `IFD_RTT) begin
            next_class  = `IFD_CLS_MISC;
            next_opcode = {6'h00, instr[2:0]};
        end else if (instr[15:6] == `IFD_WR_STATUS_OP10) begin
            next_class = `IFD_CLS_STATUS;
            next_swr   = 1'b1;                            // RULE_18
        end else if (instr[15:6] == `IFD_RD_STATUS_OP10) begin
            next_class = `IFD_CLS_STATUS;
            next_srd   = 1'b1;                            // RULE_18
        end else if (instr[15:5] == 11'o0005) begin
            next_class  = `IFD_CLS_CCODE;
            next_opcode = {4'h0, instr[4:0]};
        end else if (instr[14:12] == 3'o0 && instr[11] && (instr[10:6] >= 5'o10)
                     && (instr[10:6] <= 5'o27)) begin
            next_class  = `IFD_CLS_SINGLE;                // RULE_01
            next_opcode = instr[14:6];
            next_byte   = instr[15];                      // RULE_07
        end else if (instr[15:6] == 10'o0001 || instr[15:6] == 10'o0003) begin
            next_class  = `IFD_CLS_SINGLE;                // RULE_01
            next_opcode = instr[14:6];
        end
    end

    always @(posedge clock) begin
        irq_meta <= irq_req;
        irq_sync <= irq_meta;
    end

    always @(posedge clock) begin
        if (sys_rst) begin
            decode_valid   <= 1'b0;
            class_code     <= `IFD_CLS_RESERVED;
            opcode         <= 9'h000;
            byte_op        <= 1'b0;
            is_subtract    <= 1'b0;
            src_mode       <= 3'o0;
            src_reg        <= 3'o0;
            dst_mode       <= 3'o0;
            dst_reg        <= 3'o0;
            branch_taken   <= 1'b0;
            branch_target  <= {WIDTH{1'b0}};
            count_result   <= {WIDTH{1'b0}};
            trap_req       <= 1'b0;
            trap_kind      <= `IFD_TRP_NONE;
            status_write   <= 1'b0;
            status_read    <= 1'b0;
            proc_type_read <= 1'b0;
            proc_type      <= `IFD_PROC_TYPE;
            reserved_instr <= 1'b0;
            call_pc_link   <= 1'b0;
        end else begin
            decode_valid   <= instr_valid;
            class_code     <= next_class;
            opcode         <= next_opcode;
            byte_op        <= next_byte;
            is_subtract    <= next_sub;
            src_mode       <= next_smode;
            src_reg        <= next_sreg;
            dst_mode       <= next_dmode;
            dst_reg        <= next_dreg;
            branch_taken   <= instr_valid & next_taken;
            branch_target  <= next_target;
            count_result   <= next_decval;
            // interrupt wins over a trap instruction in the same cycle
            trap_req       <= irq_sync | (instr_valid & (next_trap != `IFD_TRP_NONE)); // RULE_17
            trap_kind      <= irq_sync ? `IFD_TRP_IRQ : next_trap;
            status_write   <= instr_valid & next_swr;
            status_read    <= instr_valid & next_srd;
            proc_type_read <= instr_valid & next_ptr;     // RULE_19
            proc_type      <= `IFD_PROC_TYPE;
            reserved_instr <= instr_valid & (next_class == `IFD_CLS_RESERVED); // RULE_22
            call_pc_link   <= instr_valid & (next_class == `IFD_CLS_CALL)
                              & (instr[8:6] == `IFD_PC_REG); // RULE_14
        end
    end

endmodule
`default_nettype wire
